// ---- core/osf_short_flags_defines.vh ----
// register map, field positions and reset values of the output short-fault flags
// How it works
// [RULE_01] a flag bit reads 1 while a short is detected on its output, else 0
// [RULE_02] index ACh resets 00h: D2..D0 on bits 6..4, C2..C0 on 2..0, 7 and 3 zero
// [RULE_03] index ADh resets 00h: F2..F0 on bits 6..4, E2..E0 on 2..0, 7 and 3 zero
// [RULE_04] first register: A2..A0 on bits 2..0, B0 on bit 4, bit 3 zero, reset zero
// [RULE_05] writes do nothing; reads return detections sampled on the device clock
`ifndef OSF_SHORT_FLAGS_DEFINES_VH
`define OSF_SHORT_FLAGS_DEFINES_VH

// register indices; byte address on the bus is four times the index
`define OSF_IDX_GROUP_A_B 8'hAB
`define OSF_IDX_GROUP_C_D 8'hAC
`define OSF_IDX_GROUP_E_F 8'hAD

// field layout inside each 8-bit flag register
`define OSF_LO_LSB 0
`define OSF_LO_MSB 2
`define OSF_RSVD_LO_BIT 3
`define OSF_HI_LSB 4
`define OSF_HI_MSB 6
`define OSF_RSVD_HI_BIT 7

// reset value of every flag register
`define OSF_FLAGS_RESET 8'h00

// cycles from the request edge to ack
`define OSF_ACK_LATENCY 1

`endif

// ---- core/osf_group_reg.v ----
// one 8-bit short-fault flag register holding two output groups of three
`include "osf_short_flags_defines.vh"

module osf_group_reg (
   input wire clk,
   input wire sys_rst,
   input wire [2:0] det_lo,
   input wire [2:0] det_hi,
   output reg [7:0] flags_r
);

   reg [7:0] flags_nxt;

   // pack both groups, reserved bits forced to zero
   always @* begin
      flags_nxt = `OSF_FLAGS_RESET;
      flags_nxt[`OSF_LO_MSB:`OSF_LO_LSB] = det_lo; // [RULE_01]
      flags_nxt[`OSF_HI_MSB:`OSF_HI_LSB] = det_hi; // [RULE_01]
      flags_nxt[`OSF_RSVD_LO_BIT] = 1'b0;
      flags_nxt[`OSF_RSVD_HI_BIT] = 1'b0;
   end

   // re-sample the detector levels every clock; no latching of past faults
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         flags_r <= `OSF_FLAGS_RESET;
      end else begin
         flags_r <= flags_nxt; // [RULE_05]
      end
   end

endmodule

// ---- core/osf_addr_match.v ----
// word-index comparator for one register of the flag bank
module osf_addr_match #(
   parameter ADDR_W = 10,
   parameter [7:0] INDEX = 8'h00
) (
   input wire [ADDR_W-1:0] adr,
   output wire hit
);

   wire [ADDR_W-1:0] byte_addr;

   // byte address is four times the register index
   assign byte_addr = {{(ADDR_W-8){1'b0}}, INDEX} << 2;
   assign hit = (adr == byte_addr);

endmodule

// ---- core/osf_short_flags.v ----
// output short-fault flag bank with a classic wishbone read-only slave port
//
// Added by the designer: the Wishbone register port.
`include "osf_short_flags_defines.vh"

module osf_short_flags #(
   parameter ADDR_W = 10
) (
   input wire clk,
   input wire sys_rst,
   input wire [2:0] short_fault_a,
   input wire [2:0] short_fault_b,
   input wire [2:0] short_fault_c,
   input wire [2:0] short_fault_d,
   input wire [2:0] short_fault_e,
   input wire [2:0] short_fault_f,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [ADDR_W-1:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o
);

   wire [7:0] short_flags_group_a_b;
   wire [7:0] short_flags_group_c_d;
   wire [7:0] short_flags_group_e_f;
   wire hit_a_b;
   wire hit_c_d;
   wire hit_e_f;
   wire req;
   reg [31:0] rd_nxt;

   // group a/b: a on the low field, b on the high field
   osf_group_reg u_grp_a_b (
      .clk(clk),
      .sys_rst(sys_rst),
      .det_lo(short_fault_a), // [RULE_04]
      .det_hi(short_fault_b), // [RULE_04]
      .flags_r(short_flags_group_a_b)
   );

   // group c/d
   osf_group_reg u_grp_c_d (
      .clk(clk),
      .sys_rst(sys_rst),
      .det_lo(short_fault_c), // [RULE_02]
      .det_hi(short_fault_d), // [RULE_02]
      .flags_r(short_flags_group_c_d)
   );

   // group e/f
   osf_group_reg u_grp_e_f (
      .clk(clk),
      .sys_rst(sys_rst),
      .det_lo(short_fault_e), // [RULE_03]
      .det_hi(short_fault_f), // [RULE_03]
      .flags_r(short_flags_group_e_f)
   );

   // address decode for the three flag registers
   osf_addr_match #(.ADDR_W(ADDR_W), .INDEX(`OSF_IDX_GROUP_A_B)) u_hit_a_b (
      .adr(wb_adr_i),
      .hit(hit_a_b)
   );

   osf_addr_match #(.ADDR_W(ADDR_W), .INDEX(`OSF_IDX_GROUP_C_D)) u_hit_c_d (
      .adr(wb_adr_i),
      .hit(hit_c_d)
   );

   osf_addr_match #(.ADDR_W(ADDR_W), .INDEX(`OSF_IDX_GROUP_E_F)) u_hit_e_f (
      .adr(wb_adr_i),
      .hit(hit_e_f)
   );

   // a new request; the ack term keeps one request from being answered twice
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   // read mux; unmapped addresses and writes return zero
   always @* begin
      rd_nxt = 32'h00000000;
      if (!wb_we_i) begin
         if (hit_a_b) begin
            rd_nxt[7:0] = short_flags_group_a_b; // [RULE_04]
         end else if (hit_c_d) begin
            rd_nxt[7:0] = short_flags_group_c_d; // [RULE_02]
         end else if (hit_e_f) begin
            rd_nxt[7:0] = short_flags_group_e_f; // [RULE_03]
         end
      end
   end

   // every access is acked one cycle later; write data and sel are dropped
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= req;
         if (req) begin
            wb_dat_o <= rd_nxt; // [RULE_05]
         end else begin
            wb_dat_o <= 32'h00000000;
         end
      end
   end

endmodule

// ---- tb/osf_short_flags_props.sv ----
// checker for the flag bank bus port
module osf_props (
   input wire clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
   input wire [2:0] short_fault_c, short_fault_d,
   input wire [9:0] wb_adr_i,
   input wire [31:0] wb_dat_o
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // bus answers
   chk_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bad ack");
   chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("bad upper bits");
   chk_rd_cd: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 10'h2B0 |->
      wb_dat_o == {25'h0, $past(short_fault_d, 2), 1'h0, $past(short_fault_c, 2)})
      else $error("bad read");
   chk_rsvd_zero: assert property (wb_ack_o |-> !wb_dat_o[7] && !wb_dat_o[3])
      else $error("bad reserved");
   chk_wr_quiet: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0)
      else $error("bad write");
   chk_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("bad idle");
   cover property (wb_ack_o && wb_we_i);
   cover property (wb_ack_o && wb_dat_o[6:4] == 3'h7);
   cover property (wb_ack_o && wb_adr_i == 10'h2B8);
endmodule
bind osf_short_flags osf_props u_props (.*);

// ---- tb/osf_short_flags_test.sv ----
// bench for the short-fault flag bank
module osf_short_flags_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, sys_rst = 1, cyc = 0, we = 0, ack;
   logic [9:0] a = 10'h0;
   logic [17:0] f = 18'h0;
   logic [31:0] r = 32'hCC8D, d, q[$];
   int n_errors = 0, total_checks = 0;
   osf_short_flags dut (.clk(clk), .sys_rst(sys_rst), .short_fault_a(f[2:0]),
      .short_fault_b(f[5:3]), .short_fault_c(f[8:6]), .short_fault_d(f[11:9]),
      .short_fault_e(f[14:12]), .short_fault_f(f[17:15]), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(a), .wb_sel_i(r[3:0]), .wb_dat_i(r), .wb_dat_o(d), .wb_ack_o(ack));
   always #4 clk = ~clk;
   function logic [31:0] nx(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task summarize;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task check(input logic [31:0] s, e);
      total_checks++;
      if (s !== e) n_errors++;
      if (s !== e) $display("MISMATCH dat_o exp %h seen %h", e, s);
   endtask
   // one classic cycle, held until ack is sampled
   task bus(input logic w, input int i, input logic [31:0] e);
      q.push_back(e);
      cyc <= 1'h1;
      we <= w;
      a <= 10'h2AC + 10'(i * 4);
      @(posedge clk);
      while (ack !== 1'h1) @(posedge clk);
      cyc <= 1'h0;
      @(posedge clk);
   endtask
   // compare each answer with the oldest note
   always @(posedge clk)
      if (ack === 1'h1) check(d, q.pop_front());
   initial #9000 begin
      n_errors++;
      summarize();
   end
   initial begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'h0;
      for (int t = 0; t < 8; t++) begin
         f <= (t == 7) ? 18'h3FFFF : r[17:0];
         r <= nx(r);
         repeat (2) @(posedge clk);
         for (int i = 0; i < 4; i++) begin
            bus(1'h1, i, 32'h0);
            bus(1'h0, i, (i > 2) ? 32'h0 : {25'h0, f[6*i+3 +:3], 1'h0, f[6*i +:3]});
         end
         $display("test %0d done", t);
      end
      summarize();
   end
endmodule
